// [timer_pkg.sv]
// Package with shared constants and types of the programmable output timer.
// Assumes a single 100 MHz clock; the filter, core and bench refer to it by timer_pkg::name.
`default_nettype none
package timer_pkg;
   // Clock period and documented times in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS       = 10_000_000;
   localparam int KEY_HOLD_NS   = 1_000_000_000;
   localparam int FLT_LONG_NS   = 20_000_000;
   localparam int FLT_SHORT_NS  = 1_000_000;
   // Cycle counts derived from the times; least times round up.
   localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   localparam int KEY_HOLD_CYC  = (KEY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLT_LONG_CYC  = (FLT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLT_SHORT_CYC = (FLT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_SET_OFF = 8'h04;
   localparam logic [7:0] ADDR_SET_ON  = 8'h08;
   localparam logic [7:0] ADDR_CYCLE   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   // Control and status field positions.
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_DOWN_BIT  = 3;
   localparam int CTRL_RANGE_LSB = 4;
   localparam int CTRL_SHORT_BIT = 6;
   localparam int CTRL_TWIN_BIT  = 7;
   localparam int ST_OUT_BIT     = 16;
   localparam int ST_RUN_BIT     = 17;
   localparam int ST_SEL_BIT     = 18;
   // Reset values.
   localparam logic [6:0]  CTRL_RST    = 7'h00;
   localparam logic [15:0] SET_RST     = 16'h0064;
   localparam logic [15:0] CYCLE_RST   = 16'h0000;
   // One-shot pulse length in ticks and the full duty figure.
   localparam logic [15:0] ONESHOT_TICKS = 16'h0032;
   localparam logic [6:0]  DUTY_FULL     = 7'h64;
   // Output modes.
   typedef enum logic [2:0] {
      MODE_FLICKER = 3'h0,
      MODE_ONESHOT = 3'h1,
      MODE_HOLD    = 3'h2,
      MODE_REPEAT  = 3'h3,
      MODE_DUTY    = 3'h4
   } out_mode_e;
   // Key sequence states, Gray coded along run, armed, selection.
   typedef enum logic [1:0] {
      UI_RUN = 2'b00,
      UI_ARM = 2'b01,
      UI_SEL = 2'b11
   } ui_state_e;
endpackage : timer_pkg
`default_nettype wire

// [input_filter.sv]
// Chatter filter for one external input.
// Assumes the raw input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
   parameter int LONG_CYC  = timer_pkg::FLT_LONG_CYC,
   parameter int SHORT_CYC = timer_pkg::FLT_SHORT_CYC
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic srst,
   // Raw level, width select and accepted level.
   input  wire logic raw,
   input  wire logic short_sel,
   output var  logic level_r
);
   localparam int CW = $clog2(LONG_CYC + 1);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] lim;

   // The accepted level follows only after the raw level stayed put for the width.
   assign lim = short_sel ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r   <= '0;
         level_r <= 1'b0;
      end else if (raw == level_r) begin
         cnt_r <= '0;
      end else if (cnt_r >= lim) begin
         cnt_r   <= '0;
         level_r <= raw;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule : input_filter
`default_nettype wire

// [prog_timer.sv]
// Control core of the programmable output timer: keys, selection mode, timing and output.
// Assumes inputs synchronous to clk, a plain register port and power_up pulsed on power return.
`timescale 1ns/1ps
`default_nettype none
module prog_timer #(
   parameter int TICK_CYC     = timer_pkg::TICK_CYC,
   parameter int KEY_HOLD_CYC = timer_pkg::KEY_HOLD_CYC,
   parameter int FLT_LONG     = timer_pkg::FLT_LONG_CYC,
   parameter int FLT_SHORT    = timer_pkg::FLT_SHORT_CYC
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        power_up,
   // External start, reset and gate inputs.
   input  wire logic        start_in,
   input  wire logic        reset_in,
   input  wire logic        gate_in,
   // Front keys and switches.
   input  wire logic        key_mode,
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic [7:0]  switches,
   // Register port.
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output var  logic [31:0] rdata_r,
   // Displays, indicators and control output.
   output var  logic [15:0] main_disp_r,
   output var  logic [15:0] sub_disp_r,
   output var  logic        off_time_indicator,
   output var  logic        on_time_indicator,
   output var  logic        sel_mode_r,
   output var  logic [7:0]  monitor_r,
   output var  logic        ctrl_out_r
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int KW = $clog2(KEY_HOLD_CYC + 1);

   timer_pkg::ui_state_e ui_r;
   logic [KW-1:0] hold_r;
   logic [6:0]  ctrl_r, pend_r;
   logic        twin_r, twin_pend_r, disp_on_r;
   logic [15:0] set_off_r, set_on_r, cycle_r, el_r, os_r;
   logic [TW-1:0] base_r;
   logic [6:0]  div_r, div_lim;
   logic        tick, run_r, start_q, reset_q, mode_q, up_q, down_q;
   logic [2:0]  flt;
   logic        enter, leave, apply_rst;
   logic [15:0] target;
   logic [2:0]  mode;
   logic        expire, start_rise, reset_fall, block;
   logic [6:0]  duty;
   logic [22:0] duty_lhs, duty_rhs;

   // One chatter filter per external input, in start, reset, gate order.
   for (genvar i = 0; i < 3; i++) begin : g_flt
      input_filter #(.LONG_CYC(FLT_LONG), .SHORT_CYC(FLT_SHORT)) u_flt (
         .clk       (clk),
         .srst      (srst),
         .raw       (i == 0 ? start_in : (i == 1 ? reset_in : gate_in)),
         .short_sel (ctrl_r[timer_pkg::CTRL_SHORT_BIT]),
         .level_r   (flt[i])
      );
   end

   // Decoded fields and events of this cycle.
   assign mode       = ctrl_r[timer_pkg::CTRL_MODE_LSB +: 3];
   assign target     = (twin_r && ctrl_out_r) ? set_on_r : set_off_r;
   assign start_rise = flt[0] && !start_q;
   assign reset_fall = !flt[1] && reset_q;
   assign enter      = (ui_r == timer_pkg::UI_ARM) && key_mode && key_up
                       && (hold_r == KW'(KEY_HOLD_CYC - 1));
   assign leave      = (ui_r == timer_pkg::UI_SEL) && key_mode && !mode_q;
   assign apply_rst  = leave && ((pend_r != ctrl_r) || (twin_pend_r != twin_r));
   assign block      = (ui_r == timer_pkg::UI_SEL) || enter || apply_rst || flt[1];
   assign expire     = run_r && tick && !flt[2] && (el_r + 16'h0001 >= target);
   assign duty       = set_off_r[6:0];
   // Present value times 100 as 128 - 32 + 4; each term is 23 bits so nothing is dropped.
   assign duty_lhs   = {el_r, 7'h00} - {2'b00, el_r, 5'h00} + {5'h00, el_r, 2'b00};
   // Both factors widened first so that the product keeps its upper bits.
   assign duty_rhs   = 23'(duty) * 23'(cycle_r);

   // Tick prescaler: base tick divided by 1, 10 or 100 by the time range.
   assign div_lim = ctrl_r[timer_pkg::CTRL_RANGE_LSB +: 2] == 2'd0 ? 7'h00 :
                    ctrl_r[timer_pkg::CTRL_RANGE_LSB +: 2] == 2'd1 ? 7'h09 : 7'h63;
   assign tick    = (base_r == TW'(TICK_CYC - 1)) && (div_r >= div_lim);
   always_ff @(posedge clk) begin
      if (srst || base_r == TW'(TICK_CYC - 1)) begin
         base_r <= '0;
      end else begin
         base_r <= base_r + 1'b1;
      end
      if (srst || tick) begin
         div_r <= '0;
      end else if (base_r == TW'(TICK_CYC - 1)) begin
         div_r <= div_r + 7'h01;
      end
   end

   // Edge history of filtered inputs and keys.
   always_ff @(posedge clk) begin
      if (srst) begin
         start_q <= 1'b0;
         reset_q <= 1'b0;
         mode_q  <= 1'b0;
         up_q    <= 1'b0;
         down_q  <= 1'b0;
      end else begin
         start_q <= flt[0];
         reset_q <= flt[1];
         mode_q  <= key_mode;
         up_q    <= key_up;
         down_q  <= key_down;
      end
   end

   // Key sequence: arm only if up is pressed while mode is already held.
   always_ff @(posedge clk) begin
      if (srst) begin
         ui_r   <= timer_pkg::UI_RUN;
         hold_r <= '0;
      end else begin
         unique case (ui_r)
            timer_pkg::UI_RUN: begin
               hold_r <= '0;
               if (key_up && !up_q && key_mode && mode_q) begin
                  ui_r <= timer_pkg::UI_ARM;
               end
            end
            timer_pkg::UI_ARM: begin
               if (!key_mode || !key_up) begin
                  ui_r <= timer_pkg::UI_RUN;
               end else if (enter) begin
                  ui_r <= timer_pkg::UI_SEL;
               end else begin
                  hold_r <= hold_r + 1'b1;
               end
            end
            timer_pkg::UI_SEL: begin
               if (leave) begin
                  ui_r <= timer_pkg::UI_RUN;
               end
            end
            default: ui_r <= timer_pkg::UI_RUN;
         endcase
      end
   end

   // Settings: control writes in selection mode wait until exit.
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r      <= timer_pkg::CTRL_RST;
         pend_r      <= timer_pkg::CTRL_RST;
         twin_r      <= 1'b0;
         twin_pend_r <= 1'b0;
         set_off_r   <= timer_pkg::SET_RST;
         set_on_r    <= timer_pkg::SET_RST;
         cycle_r     <= timer_pkg::CYCLE_RST;
      end else begin
         if (wr && addr == timer_pkg::ADDR_CTRL) begin
            pend_r <= wdata[6:0];
            if (ui_r != timer_pkg::UI_SEL) begin
               ctrl_r <= wdata[6:0];
            end
         end
         if (ui_r == timer_pkg::UI_SEL && key_down && !down_q) begin
            twin_pend_r <= !twin_pend_r;
         end
         if (leave) begin
            ctrl_r <= pend_r;
            twin_r <= twin_pend_r;
         end
         if (wr && addr == timer_pkg::ADDR_SET_OFF) set_off_r <= wdata[15:0];
         if (wr && addr == timer_pkg::ADDR_SET_ON) set_on_r <= wdata[15:0];
         if (wr && addr == timer_pkg::ADDR_CYCLE) cycle_r <= wdata[15:0];
      end
   end

   // Timing core: elapsed count, run flag, one-shot width and control output.
   always_ff @(posedge clk) begin
      if (srst) begin
         el_r       <= '0;
         run_r      <= 1'b0;
         os_r       <= '0;
         ctrl_out_r <= 1'b0;
      end else if (block) begin
         el_r       <= '0;
         run_r      <= 1'b0;
         os_r       <= '0;
         ctrl_out_r <= 1'b0;
      end else if (mode == timer_pkg::MODE_DUTY) begin
         run_r <= 1'b1;
         if (tick && !flt[2]) begin
            el_r <= (el_r + 16'h0001 >= cycle_r) ? 16'h0000 : el_r + 16'h0001;
         end
         if (cycle_r == 16'h0000 || duty == 7'h00) begin
            ctrl_out_r <= 1'b0;
         end else if (duty >= timer_pkg::DUTY_FULL) begin
            ctrl_out_r <= 1'b1;
         end else begin
            ctrl_out_r <= duty_lhs < duty_rhs;
         end
      end else if (power_up) begin
         if (mode != timer_pkg::MODE_REPEAT) begin
            el_r       <= '0;
            ctrl_out_r <= 1'b0;
         end
         run_r <= flt[0] || (mode == timer_pkg::MODE_REPEAT && run_r);
      end else if ((start_rise || reset_fall && flt[0]) && !run_r) begin
         el_r       <= '0;
         run_r      <= 1'b1;
         ctrl_out_r <= 1'b0;
      end else if (expire) begin
         el_r <= '0;
         if (mode == timer_pkg::MODE_FLICKER || mode == timer_pkg::MODE_REPEAT) begin
            ctrl_out_r <= !ctrl_out_r;
         end else begin
            ctrl_out_r <= 1'b1;
            run_r      <= 1'b0;
            os_r       <= (mode == timer_pkg::MODE_ONESHOT) ? timer_pkg::ONESHOT_TICKS : 16'h0000;
         end
      end else if (run_r && tick && !flt[2]) begin
         el_r <= el_r + 16'h0001;
      end else if (os_r != 16'h0000 && tick && !flt[2]) begin
         os_r <= os_r - 16'h0001;
         if (os_r == 16'h0001) ctrl_out_r <= 1'b0;
      end
   end

   // Displays, indicators and switch monitor.
   always_ff @(posedge clk) begin
      if (srst) begin
         disp_on_r          <= 1'b0;
         main_disp_r        <= '0;
         sub_disp_r         <= '0;
         off_time_indicator <= 1'b0;
         on_time_indicator  <= 1'b0;
         sel_mode_r         <= 1'b0;
         monitor_r          <= '0;
      end else begin
         if (ui_r == timer_pkg::UI_RUN && key_mode && !mode_q) begin
            disp_on_r <= !disp_on_r;
         end
         main_disp_r        <= ctrl_r[timer_pkg::CTRL_DOWN_BIT] ? target - el_r : el_r;
         sub_disp_r         <= disp_on_r ? set_on_r : set_off_r;
         off_time_indicator <= !disp_on_r && ui_r != timer_pkg::UI_SEL;
         on_time_indicator  <= disp_on_r && ui_r != timer_pkg::UI_SEL;
         sel_mode_r         <= ui_r == timer_pkg::UI_SEL || enter;
         monitor_r          <= (ui_r == timer_pkg::UI_SEL && switches[0]) ? switches : 8'h00;
      end
   end

   // Register reads answer in the next cycle; unmapped addresses read zero.
   always_ff @(posedge clk) begin
      if (srst || !rd) begin
         rdata_r <= '0;
      end else begin
         unique case (addr)
            timer_pkg::ADDR_CTRL:    rdata_r <= {24'h000000, twin_r, ctrl_r};
            timer_pkg::ADDR_SET_OFF: rdata_r <= {16'h0000, set_off_r};
            timer_pkg::ADDR_SET_ON:  rdata_r <= {16'h0000, set_on_r};
            timer_pkg::ADDR_CYCLE:   rdata_r <= {16'h0000, cycle_r};
            timer_pkg::ADDR_STATUS:  rdata_r <= {13'h0000, sel_mode_r, run_r, ctrl_out_r, main_disp_r};
            default:                 rdata_r <= '0;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_both_held;
      key_mode && key_up && ui_r == timer_pkg::UI_ARM;
   endsequence

   AST_OFF_IND: assert property (off_time_indicator |-> sub_disp_r == $past(set_off_r))
      else $error("off indicator lit without OFF set time shown");
   AST_ON_IND: assert property (on_time_indicator |-> sub_disp_r == $past(set_on_r))
      else $error("on indicator lit without ON set time shown");
   AST_ENTER: assert property (s_both_held ##0 (hold_r == KW'(KEY_HOLD_CYC - 1)) |=> sel_mode_r)
      else $error("selection mode not entered after hold");
   AST_NO_ENTER: assert property (ui_r == timer_pkg::UI_RUN && key_up && !up_q && !mode_q
                                  |=> ui_r == timer_pkg::UI_RUN)
      else $error("key sequence armed with up key first");
   AST_SEL_CLR: assert property ($rose(sel_mode_r) |-> el_r == 16'h0000 && !ctrl_out_r && !run_r)
      else $error("entry to selection did not clear timer");
   AST_START_IGN: assert property (run_r && start_rise && !block && !expire && !power_up
                                   && mode != timer_pkg::MODE_DUTY |=> ctrl_out_r == $past(ctrl_out_r)
                                   && el_r >= $past(el_r))
      else $error("start input disturbed a running interval");
   AST_HOLD: assert property (mode == timer_pkg::MODE_HOLD && ctrl_out_r && !block && !power_up
                              && $stable(ctrl_r) |=> ctrl_out_r)
      else $error("hold output dropped");
   AST_DUTY_OFF: assert property (mode == timer_pkg::MODE_DUTY && !block && cycle_r == 16'h0000
                                  ##1 mode == timer_pkg::MODE_DUTY && !block && cycle_r == 16'h0000 |-> !ctrl_out_r)
      else $error("duty output on with zero cycle");
   AST_DUTY_FULL: assert property (mode == timer_pkg::MODE_DUTY && !block && cycle_r != 16'h0000
                                   && duty >= timer_pkg::DUTY_FULL |=> ctrl_out_r)
      else $error("duty output off at full duty");
   AST_GATE: assert property (run_r && flt[2] && !block && !power_up && !start_rise
                              && mode != timer_pkg::MODE_DUTY |=> $stable(el_r) && $stable(ctrl_out_r))
      else $error("value advanced while gated");
endmodule : prog_timer
`default_nettype wire

// [contact_model.sv]
// Behavioural model of an external contact or sensor that feeds one timer input.
// Assumes the bench sets the wanted level at rising edges; a change chatters for bounce cycles first.
`timescale 1ns/1ps
`default_nettype none
module contact_model (
   // Clock.
   input  wire logic       clk,
   // Wanted level and chatter length in cycles.
   input  wire logic       want,
   input  wire logic [3:0] bounce,
   // Line seen by the timer.
   output var  logic       line
);
   logic       last_r;
   logic [3:0] cnt_r;
   // The line starts open.
   initial begin
      line = 1'b0;
      last_r = 1'b0;
      cnt_r = 4'h0;
   end
   // A change toggles the line once a cycle before it settles, so the filter must ride it out.
   always @(posedge clk) begin
      last_r <= want;
      if (want != last_r) begin
         cnt_r <= bounce;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
      line <= (cnt_r != 4'h0) ? ~line : want;
   end
endmodule : contact_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the programmable output timer with contact models on its inputs.
// Assumes shortened tick, key-hold and filter counts; expectations are derived from them.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int TK = 10;      // Cycles per base tick.
   localparam int KH = 20;      // Cycles of key hold before selection.
   localparam int P  = 10 * TK; // Set time of ten ticks in cycles.
   logic        clk, srst, power_up, key_mode, key_up, key_down, wr, rd;
   logic        s_want, r_want, g_want, start_in, reset_in, gate_in;
   logic        off_time_indicator, on_time_indicator, sel_mode_r, ctrl_out_r;
   logic [3:0]  bounce;
   logic [7:0]  switches, addr, monitor_r;
   logic [15:0] main_disp_r, sub_disp_r;
   logic [31:0] wdata, rdata_r, rnd, v1, v2;
   int          err_count, tests_run, cyc_cnt, t0, n, k, c, d;
   int          dtab[6] = '{0, 30, 55, 100, 50, 0};
   logic [7:0]  atab[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] etab[6] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h0, 32'h0};

   prog_timer #(.TICK_CYC(TK), .KEY_HOLD_CYC(KH), .FLT_LONG(8), .FLT_SHORT(3)) DUT (
      .clk(clk), .srst(srst), .power_up(power_up), .start_in(start_in), .reset_in(reset_in),
      .gate_in(gate_in), .key_mode(key_mode), .key_up(key_up), .key_down(key_down),
      .switches(switches), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
      .main_disp_r(main_disp_r), .sub_disp_r(sub_disp_r), .off_time_indicator(off_time_indicator),
      .on_time_indicator(on_time_indicator), .sel_mode_r(sel_mode_r), .monitor_r(monitor_r),
      .ctrl_out_r(ctrl_out_r));
   contact_model cm_start (.clk(clk), .want(s_want), .bounce(bounce), .line(start_in));
   contact_model cm_reset (.clk(clk), .want(r_want), .bounce(bounce), .line(reset_in));
   contact_model cm_gate (.clk(clk), .want(g_want), .bounce(bounce), .line(gate_in));

   // Clock of 10 ns.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cycle counter that also cuts a hang short.
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 25000) begin
         err_count = err_count + 1;
         summarize();
      end
   end

   // Pseudo-random source.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Flicker model: output level after t cycles of counted time.
   function automatic logic fexp(input int t);
      return ((t / P) % 2) == 1;
   endfunction : fexp
   // Compares of words and of single levels.
   task automatic chk_word(input string w, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string w, input logic e, input logic g);
      chk_word(w, {31'h0, e}, {31'h0, g});
   endtask : chk_bit
   // Register bus cycles; read data stand only in the cycle after the strobe.
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata_r;
   endtask : rreg
   // Timing helpers relative to the last start request.
   task automatic mark();
      @(posedge clk);
      s_want <= 1'b1;
      t0 = cyc_cnt;
   endtask : mark
   task automatic upto(input int t);
      while (cyc_cnt < t0 + t) @(posedge clk);
      @(negedge clk);
   endtask : upto
   task automatic sat(input int t, input string w, input logic e);
      upto(t);
      chk_bit(w, e, ctrl_out_r);
   endtask : sat
   // Key press of a few cycles.
   task automatic tap(input bit dn);
      @(posedge clk);
      if (dn) key_down <= 1'b1;
      else key_mode <= 1'b1;
      repeat (3) @(posedge clk);
      key_down <= 1'b0;
      key_mode <= 1'b0;
      repeat (4) @(negedge clk);
   endtask : tap
   // Releases start and pulses the reset input to leave the timer idle.
   task automatic clear();
      @(posedge clk);
      s_want <= 1'b0;
      r_want <= 1'b1;
      repeat (40) @(posedge clk);
      r_want <= 1'b0;
      repeat (40) @(posedge clk);
   endtask : clear
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   // Main sequence.
   initial begin
      {srst, power_up, key_mode, key_up, key_down, wr, rd} = 7'h40;
      {s_want, r_want, g_want, addr, wdata, switches, bounce} = '0;
      rnd = 32'h01BA;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rreg(atab[i], v1);
         chk_word("reg_reset", etab[i], v1);
      end
      wreg(timer_pkg::ADDR_CTRL, 32'h0000_0080);
      rreg(timer_pkg::ADDR_CTRL, v1);
      chk_word("twin_read_only", 32'h0, v1);
      chk_bit("off_ind", 1'b1, off_time_indicator);
      chk_word("sub_off", {16'h0, timer_pkg::SET_RST}, {16'h0, sub_disp_r});
      wreg(timer_pkg::ADDR_SET_ON, 32'h0000_0007);
      tap(1'b0);
      chk_bit("on_ind", 1'b1, on_time_indicator);
      chk_bit("off_ind_clear", 1'b0, off_time_indicator);
      chk_word("sub_on", 32'h7, {16'h0, sub_disp_r});
      tap(1'b0);
      chk_bit("off_ind_back", 1'b1, off_time_indicator);
      // Flicker with a restart attempt, a gate hold and a reset while start stays on.
      rnd = lfsr(rnd);
      bounce <= {1'b0, rnd[2:0]};
      wreg(timer_pkg::ADDR_SET_OFF, 32'h0000_000A);
      wreg(timer_pkg::ADDR_CTRL, 32'h0);
      mark();
      sat(50, "flick_first", fexp(50));
      upto(105);
      @(posedge clk) s_want <= 1'b0;
      upto(135);
      @(posedge clk) s_want <= 1'b1;
      sat(180, "flick_restart", fexp(180));
      sat(250, "flick_toggle", fexp(250));
      upto(320);
      @(posedge clk) g_want <= 1'b1;
      upto(420);
      v1 = {16'h0, main_disp_r};
      sat(450, "gate_out", fexp(320));
      chk_word("gate_value", v1, {16'h0, main_disp_r});
      upto(520);
      @(posedge clk) g_want <= 1'b0;
      sat(560, "gate_resume", fexp(360));
      sat(650, "gate_resume", fexp(450));
      upto(700);
      @(posedge clk) r_want <= 1'b1;
      sat(740, "reset_out", 1'b0);
      chk_word("reset_value", 32'h0, {16'h0, main_disp_r});
      upto(800);
      @(posedge clk) r_want <= 1'b0;
      sat(850, "release_start", fexp(50));
      sat(950, "release_start", fexp(150));
      clear();
      // One-shot ends after its pulse, hold stays on.
      for (int m = 1; m <= 2; m++) begin
         wreg(timer_pkg::ADDR_CTRL, 32'(m));
         mark();
         sat(60, "shot_early", 1'b0);
         @(posedge clk) s_want <= 1'b0;
         sat(150, "shot_on", 1'b1);
         sat(P + 50 * TK + 60, "shot_end", m == 2);
         clear();
      end
      // A five-cycle start pulse passes only the short filter.
      bounce <= 4'h0;
      for (int f = 0; f < 2; f++) begin
         wreg(timer_pkg::ADDR_CTRL, f ? 32'h0000_0041 : 32'h0000_0001);
         mark();
         repeat (5) @(posedge clk);
         s_want <= 1'b0;
         sat(160, "filter_width", f == 1);
         clear();
      end
      // Repeat mode keeps its count over a power return.
      wreg(timer_pkg::ADDR_CTRL, 32'h0000_0003);
      mark();
      upto(150);
      rreg(timer_pkg::ADDR_STATUS, v1);
      @(posedge clk) power_up <= 1'b1;
      @(posedge clk) power_up <= 1'b0;
      rreg(timer_pkg::ADDR_STATUS, v2);
      chk_bit("repeat_out", 1'b1, v2[timer_pkg::ST_OUT_BIT]);
      chk_bit("repeat_keep", 1'b1, v2[15:0] >= v1[15:0]);
      clear();
      // Ten-fold range in down mode: slower count and remaining time shown.
      wreg(timer_pkg::ADDR_CTRL, 32'h0000_0018);
      mark();
      sat(400, "range_x10", 1'b0);
      chk_bit("down_disp", 1'b1, main_disp_r >= 16'h0006 && main_disp_r <= 16'h0007);
      clear();
      // Duty mode: on-time over ten cycle periods.
      wreg(timer_pkg::ADDR_CTRL, 32'h0000_0004);
      rnd = lfsr(rnd);
      dtab[5] = int'(rnd % 101);
      for (int i = 0; i < 6; i++) begin
         c = (i == 4) ? 0 : 10;
         d = dtab[i];
         wreg(timer_pkg::ADDR_CYCLE, 32'(c));
         wreg(timer_pkg::ADDR_SET_OFF, 32'(d));
         repeat (200) @(posedge clk);
         n = 0;
         repeat (10 * P) begin
            @(negedge clk);
            if (ctrl_out_r === 1'b1) n++;
         end
         k = 0;
         for (int e = 0; e < c; e++) if (e * 100 < d * c) k++;
         chk_word("duty_on", 32'(10 * TK * k), 32'(n));
      end
      // Up key first must not enter selection.
      @(posedge clk) key_up <= 1'b1;
      @(posedge clk) key_mode <= 1'b1;
      repeat (KH + 10) @(posedge clk);
      key_up <= 1'b0;
      key_mode <= 1'b0;
      repeat (3) @(negedge clk);
      chk_bit("sel_reversed", 1'b0, sel_mode_r);
      // Mode then up, held past the hold time while the flicker output is on.
      wreg(timer_pkg::ADDR_CTRL, 32'h0);
      mark();
      upto(150);
      @(posedge clk) key_mode <= 1'b1;
      @(posedge clk) key_up <= 1'b1;
      repeat (KH - 3) @(negedge clk);
      chk_bit("sel_early", 1'b0, sel_mode_r);
      repeat (6) @(negedge clk);
      chk_bit("sel_enter", 1'b1, sel_mode_r);
      @(posedge clk);
      {key_up, key_mode, s_want} <= 3'h0;
      switches <= rnd[7:0] | 8'h01;
      repeat (3) @(negedge clk);
      chk_word("monitor_on", {24'h0, rnd[7:0] | 8'h01}, {24'h0, monitor_r});
      chk_bit("sel_out", 1'b0, ctrl_out_r);
      chk_word("sel_value", 32'h0, {16'h0, main_disp_r});
      chk_bit("sel_ind", 1'b0, off_time_indicator | on_time_indicator);
      @(posedge clk) switches <= rnd[7:0] & 8'hFE;
      repeat (3) @(negedge clk);
      chk_word("monitor_off", 32'h0, {24'h0, monitor_r});
      wreg(timer_pkg::ADDR_CTRL, 32'h0000_0040);
      rreg(timer_pkg::ADDR_CTRL, v1);
      chk_word("ctrl_pending", 32'h0, v1);
      tap(1'b1);
      repeat (300) @(negedge clk);
      chk_bit("sel_no_timing", 1'b0, ctrl_out_r);
      chk_word("sel_no_count", 32'h0, {16'h0, main_disp_r});
      tap(1'b0);
      chk_bit("sel_exit", 1'b0, sel_mode_r);
      chk_bit("exit_out", 1'b0, ctrl_out_r);
      chk_word("exit_value", 32'h0, {16'h0, main_disp_r});
      rreg(timer_pkg::ADDR_CTRL, v1);
      chk_bit("twin_applied", 1'b1, v1[timer_pkg::CTRL_TWIN_BIT]);
      chk_word("ctrl_applied", 32'h0000_00C0, v1);
      summarize();
   end
endmodule : testbench
`default_nettype wire
